// ### rtl/dll_seq.sv
// dram-side tracker of self refresh, dll switching and exit windows
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module dll_seq (
  input wire logic core_clk,
  input wire logic reset,
  input wire dll_seq_pkg::cmd_s cmd,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic dll_en,
  output logic dll_locked,
  output logic in_sr,
  output logic clk_dont_care,
  output logic abort_pulse,
  output logic [7:0] ref_count
);
  // ********************************************************************
  // state
  // ********************************************************************
  dll_seq_pkg::state_e st_q, st_d;
  logic [15:0] cnt_q, cnt_d, dll_cnt_q, dll_cnt_d;
  logic [15:0] zq_cnt_q, zq_cnt_d, mrs_cnt_q, mrs_cnt_d;
  logic dll_en_q, dll_en_d, abort_en_q, abort_en_d, pda_q, pda_d;
  logic arm_q, arm_d, pend_q, pend_d, need_ref_q, need_ref_d;
  logic abort_q, abort_d;
  logic [7:0] ref_q, ref_d;
  logic [2:0] err_q, err_d, err_set;
  logic [15:0] tim_q [dll_seq_pkg::N_TIM];
  logic [15:0] tim_d [dll_seq_pkg::N_TIM];
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic fast_ok, full_ok, allowed, acc, is_mrs, is_zq;
  logic [15:0] xs_lim;
  logic wr_acc, setup;
  logic [2:0] w1c;
  // saturating counter step
  function automatic logic [15:0] sat(input logic [15:0] v);
    sat = (v == dll_seq_pkg::CNT_MAX) ? v : v + 16'h0001;
  endfunction : sat
  // ********************************************************************
  // exit window decode
  // ********************************************************************
  always_comb begin
    is_mrs = (cmd.op == dll_seq_pkg::CMD_MRS);
    is_zq = (cmd.op == dll_seq_pkg::CMD_ZQCL) ||
      (cmd.op == dll_seq_pkg::CMD_ZQCS);
    xs_lim = abort_en_q ? tim_q[dll_seq_pkg::TI_XSA] :
      tim_q[dll_seq_pkg::TI_XS];
    fast_ok = (cnt_q >= tim_q[dll_seq_pkg::TI_XSF]);
    full_ok = (cnt_q >= xs_lim);
    allowed = (st_q == dll_seq_pkg::ST_IDLE) ||
      (cmd.op == dll_seq_pkg::CMD_DES) || full_ok ||
      (fast_ok && (is_zq || (is_mrs && !pda_q &&
      (cmd.mr == 3'h0 || cmd.mr == 3'h2 || cmd.mr == 3'h3))));
    acc = allowed && ((st_q == dll_seq_pkg::ST_IDLE) ||
      (st_q == dll_seq_pkg::ST_EXIT));
  end
  // ********************************************************************
  // sequencer next state
  // ********************************************************************
  always_comb begin
    st_d = st_q;
    cnt_d = sat(cnt_q);
    dll_cnt_d = sat(dll_cnt_q);
    zq_cnt_d = sat(zq_cnt_q);
    mrs_cnt_d = sat(mrs_cnt_q);
    dll_en_d = dll_en_q;
    abort_en_d = abort_en_q;
    pda_d = pda_q;
    arm_d = arm_q;
    pend_d = pend_q;
    need_ref_d = need_ref_q;
    abort_d = 1'b0;
    ref_d = ref_q;
    err_set = 3'b000;
    unique case (st_q)
      dll_seq_pkg::ST_IDLE: if (cmd.op == dll_seq_pkg::CMD_SRE) begin
        err_set[2] = need_ref_q;
        st_d = dll_seq_pkg::ST_SRE;
        cnt_d = 16'h0000;
        pend_d = arm_q;
        arm_d = 1'b0;
      end
      dll_seq_pkg::ST_SRE, dll_seq_pkg::ST_SR: begin
        if (cnt_q >= tim_q[dll_seq_pkg::TI_CKSRE]) begin
          st_d = dll_seq_pkg::ST_SR;
        end
        if (cmd.op == dll_seq_pkg::CMD_SRX) begin
          st_d = dll_seq_pkg::ST_EXIT;
          cnt_d = 16'h0000;
          need_ref_d = 1'b1;
          pend_d = 1'b0;
          if (abort_en_q) begin
            abort_d = 1'b1;
          end else begin
            ref_d = ref_q + 8'h01;
          end
          if (pend_q) begin
            dll_cnt_d = 16'h0000;
          end
        end
      end
      dll_seq_pkg::ST_EXIT: if (full_ok) begin
        st_d = dll_seq_pkg::ST_IDLE;
      end
    endcase
    if (!acc && (st_q == dll_seq_pkg::ST_EXIT)) begin
      err_set[0] = 1'b1;
    end
    if (acc && is_mrs) begin
      err_set[1] = (mrs_cnt_q < tim_q[dll_seq_pkg::TI_MRD]);
      mrs_cnt_d = 16'h0000;
      unique case (cmd.mr)
        3'h0: if (cmd.data[dll_seq_pkg::DLL_RST_BIT]) begin
          dll_cnt_d = 16'h0000;
        end
        3'h1: dll_en_d = cmd.data[dll_seq_pkg::DLL_EN_BIT];
        3'h3: pda_d = cmd.data[dll_seq_pkg::PDA_BIT];
        3'h4: abort_en_d = cmd.data[dll_seq_pkg::ABORT_BIT];
        3'h6: arm_d = 1'b1;
        default: ;
      endcase
    end else if (acc && (cmd.op != dll_seq_pkg::CMD_DES) &&
        (cmd.op != dll_seq_pkg::CMD_SRE)) begin
      err_set[1] = (mrs_cnt_q < tim_q[dll_seq_pkg::TI_MOD]);
    end
    if (acc && (cmd.op == dll_seq_pkg::CMD_REF)) begin
      ref_d = ref_q + 8'h01;
      need_ref_d = 1'b0;
    end
    if (acc && (cmd.op == dll_seq_pkg::CMD_ZQCL)) begin
      zq_cnt_d = 16'h0000;
    end
  end
  // sequencer registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= dll_seq_pkg::ST_IDLE;
      cnt_q <= dll_seq_pkg::CNT_MAX;
      dll_cnt_q <= dll_seq_pkg::CNT_MAX;
      zq_cnt_q <= dll_seq_pkg::CNT_MAX;
      mrs_cnt_q <= dll_seq_pkg::CNT_MAX;
      dll_en_q <= 1'b1;
      abort_en_q <= 1'b0;
      pda_q <= 1'b0;
      arm_q <= 1'b0;
      pend_q <= 1'b0;
      need_ref_q <= 1'b0;
      abort_q <= 1'b0;
      ref_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      dll_cnt_q <= dll_cnt_d;
      zq_cnt_q <= zq_cnt_d;
      mrs_cnt_q <= mrs_cnt_d;
      dll_en_q <= dll_en_d;
      abort_en_q <= abort_en_d;
      pda_q <= pda_d;
      arm_q <= arm_d;
      pend_q <= pend_d;
      need_ref_q <= need_ref_d;
      abort_q <= abort_d;
      ref_q <= ref_d;
    end
  end
  // ********************************************************************
  // apb register file
  // ********************************************************************
  always_comb begin
    setup = psel && !penable;
    wr_acc = psel && penable && pwrite;
    w1c = (wr_acc && paddr == dll_seq_pkg::OFS_ERR) ? pwdata[2:0] : 3'b000;
    err_d = (err_q & ~w1c) | err_set; // set wins over clear
    for (int i = 0; i < dll_seq_pkg::N_TIM; i++) begin
      tim_d[i] = (wr_acc && paddr == 8'(4 * i)) ? pwdata[15:0] :
        tim_q[i];
    end
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      if (paddr < 8'(4 * dll_seq_pkg::N_TIM) && paddr[1:0] == 2'b00) begin
        prdata_d[15:0] = tim_q[paddr[4:2]];
      end else if (paddr == dll_seq_pkg::OFS_STATUS) begin
        prdata_d = {8'h00, ref_q, 7'h00, (zq_cnt_q <
          tim_q[dll_seq_pkg::TI_ZQ]), pend_q, need_ref_q, pda_q,
          abort_en_q, clk_dont_care, in_sr, dll_locked, dll_en_q};
      end else if (paddr == dll_seq_pkg::OFS_ERR) begin
        prdata_d[2:0] = err_q;
      end else begin
        pslverr_d = 1'b1;
      end
    end else if (psel) begin
      pslverr_d = pslverr_q;
    end
  end
  // register file flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      err_q <= 3'b000;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      for (int i = 0; i < dll_seq_pkg::N_TIM; i++) begin
        tim_q[i] <= dll_seq_pkg::TIM_RST[i];
      end
    end else begin
      err_q <= err_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      tim_q <= tim_d;
    end
  end
  // ********************************************************************
  // outputs
  // ********************************************************************
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign dll_en = dll_en_q;
  assign dll_locked = dll_en_q &&
    (dll_cnt_q >= tim_q[dll_seq_pkg::TI_DLLK]);
  assign in_sr = (st_q == dll_seq_pkg::ST_SRE) ||
    (st_q == dll_seq_pkg::ST_SR);
  assign clk_dont_care = (st_q == dll_seq_pkg::ST_SR);
  assign abort_pulse = abort_q;
  assign ref_count = ref_q;
  // ********************************************************************
  // assertions
  // ********************************************************************
  sequence s_mr1_write;
    acc && is_mrs && cmd.mr == 3'h1;
  endsequence
  sequence s_srx_in_sr;
    in_sr && cmd.op == dll_seq_pkg::CMD_SRX;
  endsequence
  property p_dll_bit;
    @(posedge core_clk) disable iff (reset)
    s_mr1_write |=> dll_en_q == $past(cmd.data[dll_seq_pkg::DLL_EN_BIT]);
  endproperty
  a_dll_bit: assert property (p_dll_bit)
    else $error("dll enable does not follow mode register 1 bit 0");
  property p_fast_block;
    @(posedge core_clk) disable iff (reset)
    (st_q == dll_seq_pkg::ST_EXIT && !full_ok && is_mrs &&
     cmd.mr == 3'h1) |=> $stable(dll_en_q) && err_q[0];
  endproperty
  a_fast_block: assert property (p_fast_block)
    else $error("early mode register write was not refused");
  property p_abort;
    @(posedge core_clk) disable iff (reset)
    (s_srx_in_sr and abort_en_q) |=> abort_q && $stable(ref_q) ##1
      !abort_q;
  endproperty
  a_abort: assert property (p_abort)
    else $error("aborted exit advanced refresh count");
  property p_clk_dc;
    @(posedge core_clk) disable iff (reset)
    $rose(clk_dont_care) |-> $past(cnt_q) >=
      tim_q[dll_seq_pkg::TI_CKSRE] && in_sr;
  endproperty
  a_clk_dc: assert property (p_clk_dc)
    else $error("clock ignored before entry hold time");
  property p_relock;
    @(posedge core_clk) disable iff (reset)
    (s_srx_in_sr and pend_q) |=> dll_cnt_q == 16'h0000 && !pend_q;
  endproperty
  a_relock: assert property (p_relock)
    else $error("no automatic relock at exit");
  property p_exit_len;
    @(posedge core_clk) disable iff (reset)
    (st_q == dll_seq_pkg::ST_EXIT && cnt_q < xs_lim) |=>
      st_q == dll_seq_pkg::ST_EXIT;
  endproperty
  a_exit_len: assert property (p_exit_len)
    else $error("exit window ended before programmed count");
  // nothing but deselect before the fast exit count
  property p_early_cmd;
    @(posedge core_clk) disable iff (reset)
    (st_q == dll_seq_pkg::ST_EXIT && !fast_ok && !full_ok &&
     cmd.op != dll_seq_pkg::CMD_DES) |=> err_q[0];
  endproperty
  a_early_cmd: assert property (p_early_cmd)
    else $error("command before fast exit count was not refused");
  // per-device addressing keeps mode writes out of the fast window
  property p_pda_block;
    @(posedge core_clk) disable iff (reset)
    (st_q == dll_seq_pkg::ST_EXIT && !full_ok && pda_q && is_mrs) |=>
      err_q[0] && $stable(dll_en_q) && $stable(pda_q);
  endproperty
  a_pda_block: assert property (p_pda_block)
    else $error("mode write in per-device mode was not refused");
  // a dll reset write restarts the lock count
  property p_dll_reset;
    @(posedge core_clk) disable iff (reset)
    (acc && is_mrs && cmd.mr == 3'h0 &&
     cmd.data[dll_seq_pkg::DLL_RST_BIT]) |=>
      dll_cnt_q == 16'h0000;
  endproperty
  a_dll_reset: assert property (p_dll_reset)
    else $error("dll reset write did not restart the lock count");
endmodule : dll_seq

// ### rtl/dll_seq_pkg.sv
// package: constants and types for the dll mode and clock change sequencer
// What this block does
// - mode register 1 bit 0 sets dll enable
// - fast exit allows zq, cl/wr/cwl/gear-down writes only
// - abort on exit skips refresh counter, tXS_ABORT
// - clock ignored in self refresh after tCKSRE
// - lock value before entry relocks at exit automatically
package dll_seq_pkg;
  // ********************************************************************
  // command and state encodings
  // ********************************************************************
  typedef enum logic [3:0] {
    CMD_DES = 4'h0, CMD_MRS = 4'h1, CMD_REF = 4'h2, CMD_SRE = 4'h3,
    CMD_SRX = 4'h4, CMD_ZQCL = 4'h5, CMD_ZQCS = 4'h6, CMD_ACT = 4'h7,
    CMD_PRE = 4'h8, CMD_RD = 4'h9, CMD_WR = 4'hA, CMD_PDE = 4'hB
  } cmd_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_SRE = 2'b01, ST_SR = 2'b10, ST_EXIT = 2'b11
  } state_e;
  typedef struct packed {
    cmd_e op;
    logic [2:0] mr;
    logic [13:0] data;
  } cmd_s;
  // ********************************************************************
  // mode register fields
  // ********************************************************************
  localparam int DLL_EN_BIT = 0;
  localparam int DLL_RST_BIT = 8;
  localparam int ABORT_BIT = 9;
  localparam int PDA_BIT = 4;
  // ********************************************************************
  // register map and reset values
  // ********************************************************************
  localparam int N_TIM = 8;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_ERR = 8'h24;
  localparam int TI_CKSRE = 0;
  localparam int TI_XSF = 1;
  localparam int TI_XS = 2;
  localparam int TI_XSA = 3;
  localparam int TI_DLLK = 4;
  localparam int TI_ZQ = 5;
  localparam int TI_MOD = 6;
  localparam int TI_MRD = 7;
  localparam logic [15:0] TIM_RST [N_TIM] = '{
    16'h000A, 16'h0040, 16'h0100, 16'h0040,
    16'h0300, 16'h0200, 16'h0018, 16'h0008};
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
endpackage : dll_seq_pkg

// ### sim/ctrl_model.sv
// partner model: memory controller driving the command stream
`timescale 1ns/1ps
module ctrl_model (
  output dll_seq_pkg::cmd_s cmd,
  input wire logic core_clk
);
  // ********************************************************************
  // command issue
  // ********************************************************************
  // deselect from time zero; no power-down is ever issued, so cke
  // stays high and odt steady through every exit
  initial cmd = '0;
  // one command, then deselect for gap cycles; callers hand in the
  // tMOD, tCKSRE and exit waits as gap
  // the clock is only ever the one rate, so no change outside sr
  task automatic send(input dll_seq_pkg::cmd_e c, input logic [2:0] mr,
    input logic [13:0] d, input int gap);
    @(posedge core_clk);
    cmd <= '{op: c, mr: mr, data: d};
    @(posedge core_clk);
    cmd <= '0;
    repeat (gap) @(posedge core_clk);
  endtask : send
endmodule : ctrl_model

// ### sim/tb_dll_mode_clock_change_seq.sv
// testbench: self refresh, dll switching and exit window checks
`timescale 1ns/1ps
`define CHK(nm, got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("Error %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module tb_dll_mode_clock_change_seq;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic dll_en, dll_locked, in_sr, clk_dont_care, abort_pulse;
  logic [7:0] paddr, ref_count, refs;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] tim [8];
  logic [13:0] rd0;
  dll_seq_pkg::cmd_s cmd;
  int err_count, num_checks, seed, n;
  int cksre, xsf, xs, xsa, dllk, tmod;
  dll_seq DUT (.core_clk(core_clk), .reset(reset), .cmd(cmd),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dll_en(dll_en), .dll_locked(dll_locked),
    .in_sr(in_sr), .clk_dont_care(clk_dont_care),
    .abort_pulse(abort_pulse), .ref_count(ref_count));
  ctrl_model ctrl (.cmd(cmd), .core_clk(core_clk));
  // ********************************************************************
  // clock, bus tasks and expectations
  // ********************************************************************
  // 250 MHz core clock
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;
  // expected status word for the checked bits
  function automatic logic [31:0] stat(input logic en, input logic lk,
    input logic ab, input logic [7:0] rc);
    return {8'h00, rc, 11'h000, ab, 2'b00, lk, en};
  endfunction : stat
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_count++;
      test_done();
    end
  endtask : apb
  // masked read compare
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    `CHK("read data", rd & m, e)
  endtask : rchk
  // verdict and end of run
  task automatic test_done();
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    test_done();
  end
  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {err_count, num_checks} = '0;
    reset = 1'b1;
    refs = 8'h00;
    seed = 32'h192527fc;
    tim = '{16'h0003, 16'h0004, 16'h003C, 16'h0008,
      16'h0019, 16'h0008, 16'h0004, 16'h0002};
    tim[dll_seq_pkg::TI_XS] = 16'h003C + 16'($random(seed) & 32'h7);
    rd0 = 14'($random(seed)) & 14'h3EFF;
    cksre = int'(tim[dll_seq_pkg::TI_CKSRE]);
    xsf = int'(tim[dll_seq_pkg::TI_XSF]);
    xs = int'(tim[dll_seq_pkg::TI_XS]);
    xsa = int'(tim[dll_seq_pkg::TI_XSA]);
    dllk = int'(tim[dll_seq_pkg::TI_DLLK]);
    tmod = int'(tim[dll_seq_pkg::TI_MOD]);
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    // reset state, timing defaults, programmed counts, unmapped place
    rchk(dll_seq_pkg::OFS_STATUS, 32'h00FF001F,
      stat(1'b1, 1'b1, 1'b0, 8'h00));
    for (int i = 0; i < dll_seq_pkg::N_TIM; i++) begin
      rchk(8'(i * 4), '1, {16'h0000, dll_seq_pkg::TIM_RST[i]});
      apb(1'b1, 8'(i * 4), {16'h0000, tim[i]});
      rchk(8'(i * 4), '1, {16'h0000, tim[i]});
    end
    apb(1'b0, 8'h28, 32'h00000000);
    `CHK("unmapped err", {er, rd}, 33'h100000000)
    // dll on to off through self refresh, plain exit
    ctrl.send(dll_seq_pkg::CMD_MRS, 3'h1, 14'h0000, tmod + 1);
    `CHK("dll_en off", dll_en, 1'b0)
    ctrl.send(dll_seq_pkg::CMD_SRE, 3'h0, 14'h0000, 0);
    #1;
    `CHK("in_sr", in_sr, 1'b1)
    `CHK("clk dc early", clk_dont_care, 1'b0)
    n = 0;
    while (clk_dont_care !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK("clk dc delay", n == cksre + 1, 1'b1)
    repeat (4) @(posedge core_clk);
    ctrl.send(dll_seq_pkg::CMD_SRX, 3'h0, 14'h0000, 0);
    #1;
    `CHK("in_sr exit", in_sr, 1'b0)
    `CHK("ref count exit", ref_count, refs + 8'h01)
    refs++;
    ctrl.send(dll_seq_pkg::CMD_ACT, 3'h0, 14'h0000, xsf);
    rchk(dll_seq_pkg::OFS_ERR, 32'h7, 32'h1);
    apb(1'b1, dll_seq_pkg::OFS_ERR, 32'h00000007);
    ctrl.send(dll_seq_pkg::CMD_MRS, 3'h0, rd0, tmod + 1);
    rchk(dll_seq_pkg::OFS_ERR, 32'h7, 32'h0);
    ctrl.send(dll_seq_pkg::CMD_MRS, 3'h1, 14'h0001, tmod + 1);
    rchk(dll_seq_pkg::OFS_ERR, 32'h7, 32'h1);
    `CHK("dll_en refused", dll_en, 1'b0)
    apb(1'b1, dll_seq_pkg::OFS_ERR, 32'h00000007);
    repeat (xs) @(posedge core_clk);
    ctrl.send(dll_seq_pkg::CMD_REF, 3'h0, 14'h0000, 2);
    refs++;
    `CHK("ref count", ref_count, refs)
    rchk(dll_seq_pkg::OFS_ERR, 32'h7, 32'h0);
    // dll off to on with abort exit, then dll reset and relock
    ctrl.send(dll_seq_pkg::CMD_MRS, 3'h4, 14'h0200, tmod + 1);
    ctrl.send(dll_seq_pkg::CMD_SRE, 3'h0, 14'h0000, cksre + 6);
    ctrl.send(dll_seq_pkg::CMD_SRX, 3'h0, 14'h0000, 0);
    #1;
    `CHK("abort pulse", abort_pulse, 1'b1)
    `CHK("ref count abort", ref_count, refs)
    @(posedge core_clk);
    #1;
    `CHK("abort pulse end", abort_pulse, 1'b0)
    repeat (xsa + 2) @(posedge core_clk);
    ctrl.send(dll_seq_pkg::CMD_MRS, 3'h1, 14'h0001, tmod + 1);
    `CHK("dll_en on", dll_en, 1'b1)
    ctrl.send(dll_seq_pkg::CMD_MRS, 3'h0, 14'h0100, 0);
    #1;
    `CHK("unlocked", dll_locked, 1'b0)
    repeat (dllk + 2) @(posedge core_clk);
    #1;
    `CHK("locked", dll_locked, 1'b1)
    rchk(dll_seq_pkg::OFS_STATUS, 32'h00FF001F,
      stat(1'b1, 1'b1, 1'b1, refs));
    rchk(dll_seq_pkg::OFS_ERR, 32'h7, 32'h0);
    // lock value written before entry relocks at exit
    ctrl.send(dll_seq_pkg::CMD_REF, 3'h0, 14'h0000, 2);
    refs++;
    ctrl.send(dll_seq_pkg::CMD_MRS, 3'h6, 14'h0000, tmod + 1);
    ctrl.send(dll_seq_pkg::CMD_SRE, 3'h0, 14'h0000, cksre + 6);
    ctrl.send(dll_seq_pkg::CMD_SRX, 3'h0, 14'h0000, 3);
    #1;
    `CHK("relock start", dll_locked, 1'b0)
    repeat (dllk + 2) @(posedge core_clk);
    #1;
    `CHK("relock done", dll_locked, 1'b1)
    // self refresh again with no refresh since the last exit
    ctrl.send(dll_seq_pkg::CMD_SRE, 3'h0, 14'h0000, 2);
    rchk(dll_seq_pkg::OFS_ERR, 32'h7, 32'h4);
    // fast window: long calibration taken and busy for its time
    apb(1'b1, dll_seq_pkg::OFS_ERR, 32'h00000007);
    ctrl.send(dll_seq_pkg::CMD_SRX, 3'h0, 14'h0000, xsf);
    ctrl.send(dll_seq_pkg::CMD_ZQCL, 3'h0, 14'h0000, 0);
    rchk(dll_seq_pkg::OFS_STATUS, 32'h100, 32'h100);
    rchk(dll_seq_pkg::OFS_ERR, 32'h7, 32'h0);
    repeat (int'(tim[dll_seq_pkg::TI_ZQ])) @(posedge core_clk);
    rchk(dll_seq_pkg::OFS_STATUS, 32'h100, 32'h000);
    // mode writes closer than the mode write spacing
    ctrl.send(dll_seq_pkg::CMD_MRS, 3'h2, 14'h0000, 0);
    ctrl.send(dll_seq_pkg::CMD_MRS, 3'h2, 14'h0000, tmod + 1);
    rchk(dll_seq_pkg::OFS_ERR, 32'h7, 32'h2);
    // per-device addressing refuses mode writes in the fast window
    apb(1'b1, dll_seq_pkg::OFS_ERR, 32'h00000007);
    ctrl.send(dll_seq_pkg::CMD_REF, 3'h0, 14'h0000, 2);
    ctrl.send(dll_seq_pkg::CMD_MRS, 3'h3, 14'h0010, tmod + 1);
    rchk(dll_seq_pkg::OFS_STATUS, 32'h20, 32'h20);
    ctrl.send(dll_seq_pkg::CMD_SRE, 3'h0, 14'h0000, cksre + 6);
    ctrl.send(dll_seq_pkg::CMD_SRX, 3'h0, 14'h0000, xsf);
    ctrl.send(dll_seq_pkg::CMD_MRS, 3'h0, 14'h0000, xsa);
    rchk(dll_seq_pkg::OFS_ERR, 32'h7, 32'h1);
    test_done();
  end
endmodule : tb_dll_mode_clock_change_seq
